// ---- sibc_regs.vh ----
/*
 upper configuration bytes of a clock buffer: byte indices, field positions,
 reset values. assumes byte-indexed access by an smbus protocol engine.
*/
`ifndef SIBC_REGS_VH
`define SIBC_REGS_VH
// ----------------------------------------
// byte indices
// ----------------------------------------
`define SIBC_IDX_RSVD_A 8'h04
`define SIBC_IDX_VENDOR_REV 8'h05
`define SIBC_IDX_PART_ID 8'h06
`define SIBC_IDX_READ_LEN 8'h07
`define SIBC_IDX_RSVD_B 8'h08
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SIBC_REV_MSB 7
`define SIBC_REV_LSB 4
`define SIBC_MAKER_MSB 3
`define SIBC_MAKER_LSB 0
`define SIBC_LEN_MSB 4
`define SIBC_LEN_LSB 0
`define SIBC_LEN_RESET 5'h08
`define SIBC_RSVD_VALUE 8'h00
`endif

// ---- sibc_len_reg.v ----
/*
 five-bit read length register held in byte 7.
 assumes write strobes come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sibc_regs.vh"
module sibc_len_reg (
   input wire clk,
   input wire rstn,
   input wire wr_en,
   input wire [4:0] wr_data,
   output reg [4:0] len
);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         len <= `SIBC_LEN_RESET;
      end else if (wr_en) begin
         len <= wr_data;
      end
   end
endmodule // sibc_len_reg
`default_nettype wire

// ---- sibc_upper_regs.v ----
/*
 byte-indexed upper configuration bytes 4..8 and block read sequencing.
 assumes an smbus engine on clk that presents byte index, write strobes
 and per-byte read requests; the engine handles bits, acks and addresses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sibc_regs.vh"
// Behaviour
// - byte 7 holds a five-bit writable length field in bits 4..0, bits 7..5 read zero.
// - the written length sets how many bytes a later block read returns.
// - after reset the length is 8 so a block read returns nine bytes.
// - byte 5 is read-only revision in bits 7..4 and maker code in bits 3..0.
// - a block read sends the count first, then bytes from the start index onward.
module sibc_upper_regs #(
   parameter [3:0] SILICON_REV = 4'h0, // arbitrary value
   parameter [3:0] MAKER_CODE = 4'h0, // arbitrary value
   parameter [7:0] PART_CODE = 8'h00 // arbitrary value
) (
   input wire clk,
   input wire rstn,
   input wire wr_en,
   input wire [7:0] wr_index,
   input wire [7:0] wr_data,
   input wire blk_start,
   input wire [7:0] blk_index,
   input wire byte_req,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg rd_is_count,
   output reg [7:0] rd_index,
   output wire [4:0] read_len,
   output reg blk_busy
);
   // ----------------------------------------
   // byte decode
   // ----------------------------------------
   function [7:0] byte_at;
      input [7:0] idx;
      input [4:0] len;
      begin
         case (idx)
            `SIBC_IDX_VENDOR_REV: byte_at = {SILICON_REV, MAKER_CODE};
            `SIBC_IDX_PART_ID: byte_at = PART_CODE;
            `SIBC_IDX_READ_LEN: byte_at = {3'h0, len};
            default: byte_at = `SIBC_RSVD_VALUE;
         endcase
      end
   endfunction

   wire len_wr = wr_en && (wr_index == `SIBC_IDX_READ_LEN);
   sibc_len_reg u_len (
      .clk(clk),
      .rstn(rstn),
      .wr_en(len_wr),
      .wr_data(wr_data[`SIBC_LEN_MSB:`SIBC_LEN_LSB]),
      .len(read_len)
   );

   // ----------------------------------------
   // block read sequencer
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_COUNT = 3'h2;
   localparam [2:0] ST_DATA = 3'h4;
   reg [2:0] state;
   reg [7:0] cur_index;
   reg [4:0] left;
   reg [4:0] blk_len;
   reg [2:0] next_state;
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (blk_start) next_state = ST_COUNT;
         end
         ST_COUNT: begin
            if (byte_req) next_state = ST_DATA;
         end
         ST_DATA: begin
            if (byte_req && left == 5'h00) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end
   // count sampled at start so a mid-read write cannot change this read's count or byte total; byte 7 data uses live read_len
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         cur_index <= 8'h00;
         left <= 5'h00;
         blk_len <= 5'h00;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         rd_is_count <= 1'b0;
         rd_index <= 8'h00;
         blk_busy <= 1'b0;
      end else begin
         state <= next_state;
         rd_valid <= 1'b0;
         rd_is_count <= 1'b0;
         blk_busy <= (next_state != ST_IDLE);
         case (state)
            ST_IDLE: begin
               if (blk_start) begin
                  cur_index <= blk_index;
                  blk_len <= read_len;
               end
            end
            ST_COUNT: begin
               if (byte_req) begin
                  // a count of n sends n+1 bytes, matching the nine-byte default
                  rd_data <= {3'h0, blk_len};
                  rd_valid <= 1'b1;
                  rd_is_count <= 1'b1;
                  left <= blk_len;
               end
            end
            ST_DATA: begin
               if (byte_req) begin
                  rd_data <= byte_at(cur_index, read_len);
                  rd_index <= cur_index;
                  rd_valid <= 1'b1;
                  cur_index <= cur_index + 8'h01;
                  left <= left - 5'h01;
               end
            end
            default: begin
               rd_valid <= 1'b0;
            end
         endcase
      end
   end
endmodule // sibc_upper_regs
`default_nettype wire

// ---- sibc_chk.sv ----
/* assertions on sibc_upper_regs ports; bound from tb_top */
`timescale 1ns/1ps
`default_nettype none
module sibc_chk (
input wire clk,
input wire rstn,
input wire wr_en,
input wire [7:0] wr_index,
input wire [7:0] wr_data,
input wire byte_req,
input wire blk_busy,
input wire rd_valid,
input wire [7:0] rd_data,
input wire rd_is_count,
input wire [4:0] read_len
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
sequence take_s; byte_req && blk_busy; endsequence
sequence cnt_s; rd_valid && rd_is_count; endsequence
wire lw = wr_en && wr_index == 8'h07;
len_write_a: assert property (lw |=> read_len == $past(wr_data[4:0])) else $error("len");
len_keep_a: assert property (!lw |=> $stable(read_len)) else $error("keep");
answer_a: assert property (take_s |=> rd_valid) else $error("answer");
cause_a: assert property (rd_valid |-> $past(byte_req)) else $error("cause");
idle_a: assert property (!blk_busy |=> !rd_valid) else $error("idle");
count_a: assert property (cnt_s |-> rd_data == {3'h0, read_len}) else $error("count");
endmodule // sibc_chk
`default_nettype wire

// ---- sibc_host.sv ----
/* host model: writes, block reads into got */
`timescale 1ns/1ps
`default_nettype none
module sibc_host (
input wire clk,
input wire rd_valid,
input wire [7:0] rd_data,
output logic wr_en,
output logic [7:0] wr_index,
output logic [7:0] wr_data,
output logic blk_start,
output logic [7:0] blk_index,
output logic byte_req
);
logic [7:0] got [0:32];
initial {wr_en, wr_index, wr_data, blk_start, blk_index, byte_req} = 27'h0;
// released lines show the inverse so stale values are not trusted
task wr(input [7:0] i, input [7:0] d);
   @(posedge clk) {wr_en, wr_index, wr_data} <= {1'b1, i, d};
   @(posedge clk) {wr_en, wr_index, wr_data} <= {1'b0, ~i, ~d};
endtask
task rd(input [7:0] n, input int gap);
   int k;
   @(posedge clk) {blk_start, blk_index} <= {1'b1, n};
   @(posedge clk) {blk_start, blk_index} <= {1'b0, ~n};
   for (k = 0; k == 0 || k < got[0] + 2; k++) begin
      repeat (gap) @(posedge clk);
      @(posedge clk) byte_req <= 1'b1;
      @(posedge clk) byte_req <= 1'b0;
      @(negedge clk) if (rd_valid !== 1'b1) begin
         tb_top.error_cnt++;
         tb_top.tally_and_finish();
      end
      got[k] = rd_data;
   end
endtask
endmodule // sibc_host
`default_nettype wire

// ---- tb_top.sv ----
/* bench for sibc_upper_regs driven through sibc_host */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic clk = 1'b0;
logic rstn = 1'b0;
int error_cnt = 0;
int num_checks = 0;
wire wr_en, blk_start, byte_req, rd_valid, rd_is_count, blk_busy;
wire [7:0] wr_index, wr_data, blk_index, rd_data, rd_index;
wire [4:0] read_len;
initial forever #50 clk = ~clk;
// identity values are arbitrary
sibc_upper_regs #(.SILICON_REV(4'hA), .MAKER_CODE(4'h5), .PART_CODE(8'h3C)) sibc_upper_regs_inst (.clk, .rstn,
   .wr_en, .wr_index, .wr_data, .blk_start, .blk_index, .byte_req, .rd_data, .rd_valid, .rd_is_count,
   .rd_index, .read_len, .blk_busy);
sibc_host sibc_host_inst (.clk, .rd_valid, .rd_data, .wr_en, .wr_index, .wr_data, .blk_start, .blk_index, .byte_req);
task chk(input string nm, input logic [7:0] s, e);
   num_checks++;
   if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
   end
endtask
function [7:0] ev(input [7:0] i, input [4:0] l);
   ev = i == 8'h05 ? 8'hA5 : i == 8'h06 ? 8'h3C : i == 8'h07 ? {3'h0, l} : 8'h00;
endfunction
task blk(input [7:0] n, input [4:0] l, input int gap);
   int k;
   sibc_host_inst.rd(n, gap);
   chk("count", sibc_host_inst.got[0], {3'h0, l});
   for (k = 1; k <= l + 1; k++) chk("byte", sibc_host_inst.got[k], ev(n + k - 1, l));
   chk("last index", rd_index, n + {3'h0, l});
   chk("busy after", {7'h0, blk_busy}, 8'h00);
endtask
task t_default;
   chk("len", {3'h0, read_len}, 8'h08);
   blk(8'h04, 5'h08, 0);
endtask
task t_write;
   int i;
   sibc_host_inst.wr(8'h07, 8'hFF);
   for (i = 4; i <= 8; i += (i == 6) ? 2 : 1) sibc_host_inst.wr(i[7:0], 8'h00);
   @(negedge clk) chk("len", {3'h0, read_len}, 8'h1F);
   blk(8'h05, 5'h1F, 2);
   sibc_host_inst.wr(8'h07, 8'h00);
   blk(8'h07, 5'h00, 0);
   sibc_host_inst.wr(8'h07, 8'hE2);
   blk(8'h05, 5'h02, 1);
endtask
task tally_and_finish;
   $display("checks %0d errors %0d", num_checks, error_cnt);
   if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
endtask
initial begin
   repeat (16) @(posedge clk);
   rstn <= 1'b1;
   t_default;
   t_write;
   tally_and_finish;
end
endmodule // tb_top
bind sibc_upper_regs sibc_chk sibc_chk_inst (.clk, .rstn, .wr_en, .wr_index, .wr_data, .byte_req, .blk_busy,
   .rd_valid, .rd_data, .rd_is_count, .read_len);
`default_nettype wire
